// >>> tb/pwm_output_control_stage_tb.sv
// Self-checking bench for the output control stage: registers, waveforms, crossover, interrupt.
// Assumes pwmocs_top with four units; the switch model watches unit zero.
`timescale 1ns/1ps

module pwm_output_control_stage_tb;
    import pwmocs_pkg::*;
    localparam int HQ = 10;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [3:0] pol = 4'h0, ah, al, bh, bl;
    logic hreadyout, pwm_irq;
    logic [31:0] mdl [int];
    logic [5:0] offs [8] = '{6'h00, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20};
    int last_w [4];
    int shoot, failures = 0, tests_run = 0, seed = 32'hB22A;
    // 200 MHz clock
    initial forever #2.5 hclk = ~hclk;
    pwmocs_top #(.NUM_UNITS(4)) u_pwmocs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .pwm_irq(pwm_irq), .pair_a_high_pin(ah), .pair_a_low_pin(al), .pair_b_high_pin(bh),
        .pair_b_low_pin(bl));
    pwmocs_switch_model u_pwmocs_switch_model (.clk(hclk), .clr(clr),
        .pins({bl[0], bh[0], al[0], ah[0]}), .pol(pol), .last_w(last_w), .shoot(shoot));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Write and keep the stored field bits in the register model
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] m;
        bus(1'b1, a, d);
        case (a[5:0])
            OFF_UNIT_CONTROL: m = 32'h3;
            OFF_OUTPUT_DISABLE: m = 32'h3F;
            OFF_POLARITY_SELECT: m = 32'hF;
            default: m = 32'hFFFF;
        endcase
        if (a[8]) m = (a[5:0] == OFF_GLOBAL_CONTROL) ? 32'hFF : 32'h0;
        mdl[a] = d & m;
    endtask
    task automatic rdc(input logic [11:0] a);
        bus(1'b0, a, 32'h0);
        check(rd, mdl.exists(a) ? mdl[a] : 32'h0);
    endtask
    // Program unit zero, settle, then measure one clean window of pulses
    task automatic wave(input int d, input int db, input int dt, input int dl,
            input logic [3:0] pl, input logic sw);
        int eh, el;
        eh = 2 * (HQ + d - dt);
        el = 2 * (HQ - dl - dt);
        wr(12'h00C, d);
        wr(12'h010, db);
        wr(12'h018, dt);
        wr(12'h01C, {26'h0, 1'b0, sw, 4'h0});
        wr(12'h020, {28'h0, pl});
        pol <= pl;
        repeat (130) @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (130) @(posedge hclk);
        check(last_w[0], sw ? el : eh);
        check(last_w[1], sw ? eh : el);
        check(last_w[2], 2 * (HQ + db - dt));
        check(last_w[3], 2 * (HQ - db - dt));
        check(shoot, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [11:0] a;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int k = 0; k < 36; k += 4) rdc(k[11:0]);
        rdc(12'h200);
        bus(1'b0, 12'h024, 32'h0);
        check(rd, 32'hF);
        wr(12'h008, 2 * HQ);
        wr(12'h100, 32'h1);
        wave(0, 0, 0, 0, 4'h0, 1'b0);
        wr(12'h000, 32'h2);
        wave(3, -2, 1, 3, 4'h0, 1'b0);
        wave(-4, 5, 2, -4, 4'hF, 1'b0);
        wave(2, 0, 1, 2, 4'h0, 1'b1);
        wr(12'h014, 32'h6);
        wave(1, 0, 0, 6, 4'h0, 1'b0);
        wr(12'h01C, 32'h2);
        repeat (200) @(posedge hclk);
        bus(1'b0, 12'h024, 32'h0);
        check(rd[1], 1'b1);
        wr(12'h000, 32'h1);
        repeat (50) @(posedge hclk);
        check(pwm_irq, 1'b1);
        wr(12'h100, 32'h0);
        bus(1'b0, 12'h104, 32'h0);
        check(rd, 32'h1);
        wr(12'h000, 32'h0);
        repeat (2) @(posedge hclk);
        check(pwm_irq, 1'b0);
        wr(12'h104, 32'h1);
        bus(1'b0, 12'h104, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 24; i++) begin
            a = (i % 6 == 0) ? 12'h100 : {4'h0, 2'($random(seed)), offs[3'($random(seed))]};
            wr(a, $random(seed));
            rdc(a);
        end
        conclude();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        conclude();
    end
endmodule

// >>> tb/pwmocs_switch_model.sv
// Switch drivers of one unit: pin levels to switch states, pulse widths, shoot-through.
// Assumes the bench gives the polarity in use and a clear strobe between measurements.
`timescale 1ns/1ps

module pwmocs_switch_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic [3:0] pins,
    input wire logic [3:0] pol,
    output int last_w [4],
    output int shoot
);
    int run [4];
    logic [3:0] on;
    // A switch conducts while its pin sits at the active level
    assign on = ~(pins ^ pol);
    // Width of each finished on-pulse and count of both-on cycles
    always @(posedge clk) begin
        shoot <= clr ? 0 : shoot + int'((on[0] && on[1]) || (on[2] && on[3]));
        for (int i = 0; i < 4; i++) begin
            run[i] <= on[i] ? run[i] + 1 : 0;
            if (clr) last_w[i] <= 0;
            else if (!on[i] && run[i] > 0) last_w[i] <= run[i];
        end
    end
endmodule

// >>> tb/pwmocs_top_asserts.sv
// Checker for the output control stage: bus answer, readback and interrupt relations.
// Assumes it is bound to pwmocs_top and sees only its ports.
`timescale 1ns/1ps

module pwmocs_top_chk
    import pwmocs_pkg::*;
#(
    parameter int NUM_UNITS = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic pwm_irq,
    input wire logic [NUM_UNITS-1:0] pair_a_high_pin,
    input wire logic [NUM_UNITS-1:0] pair_a_low_pin,
    input wire logic [NUM_UNITS-1:0] pair_b_high_pin,
    input wire logic [NUM_UNITS-1:0] pair_b_low_pin
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd;
    logic wdp;
    logic [3:0] pins;
    // Read taken now, and unit zero pin group
    assign rd = hsel && htrans == HTRANS_NONSEQ && hready && !hwrite;
    assign pins = {pair_b_low_pin[0], pair_b_high_pin[0], pair_a_low_pin[0], pair_a_high_pin[0]};
    // Marks the data phase of a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdp <= 1'b0;
        end else begin
            wdp <= hsel && htrans == HTRANS_NONSEQ && hready && hwrite;
        end
    end
    sequence s_rd(logic [11:0] a); rd && haddr[11:0] == a; endsequence
    property p_okay; hresp == HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("answer not okay");
    property p_ready; $past(hresetn) |-> hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("not ready");
    property p_pins; s_rd(12'h024) |=> hrdata == {28'h0, $past(pins)}; endproperty
    a_pins: assert property (p_pins) else $error("pin readback wrong");
    property p_phase; s_rd(12'h004) |=> hrdata[31:1] == 31'h0; endproperty
    a_phase: assert property (p_phase) else $error("status upper bits set");
    property p_gstat; s_rd(12'h104) |=> hrdata[31:4] == 28'h0; endproperty
    a_gstat: assert property (p_gstat) else $error("flag upper bits set");
    property p_unmap; rd && haddr[11:0] >= 12'h108 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !rd |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_irq; $fell(pwm_irq) |-> $past(wdp) || $past(wdp, 2) || $past(wdp, 3); endproperty
    a_irq: assert property (p_irq) else $error("interrupt fell without write");
endmodule

bind pwmocs_top pwmocs_top_chk #(.NUM_UNITS(NUM_UNITS)) u_pwmocs_top_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwm_irq(pwm_irq), .pair_a_high_pin(pair_a_high_pin),
    .pair_a_low_pin(pair_a_low_pin), .pair_b_high_pin(pair_b_high_pin),
    .pair_b_low_pin(pair_b_low_pin));

// >>> verilog/pwmocs_pkg.sv
// Package for the PWM output control stage: register map, field layout, reset values.
// Assumes a single AHB-Lite master and 32-bit aligned word accesses.
package pwmocs_pkg;

    // Register map: per-unit blocks with a fixed stride, globals above them
    localparam int PWMOCS_ADDR_W = 12;
    localparam int PWMOCS_UNIT_SHIFT = 6;
    localparam int PWMOCS_UNIT_IDX_W = 2;
    localparam int PWMOCS_OFF_W = 6;
    localparam logic [11:0] PWMOCS_GLOBAL_BASE = 12'h100;

    // Offsets inside one unit block
    localparam logic [5:0] OFF_UNIT_CONTROL = 6'h00;
    localparam logic [5:0] OFF_UNIT_STATUS = 6'h04;
    localparam logic [5:0] OFF_PERIOD_COUNT = 6'h08;
    localparam logic [5:0] OFF_DUTY_CHAN_A = 6'h0C;
    localparam logic [5:0] OFF_DUTY_CHAN_B = 6'h10;
    localparam logic [5:0] OFF_DUTY_CHAN_A_LOW = 6'h14;
    localparam logic [5:0] OFF_DEAD_TIME_COUNT = 6'h18;
    localparam logic [5:0] OFF_OUTPUT_DISABLE = 6'h1C;
    localparam logic [5:0] OFF_POLARITY_SELECT = 6'h20;
    localparam logic [5:0] OFF_PIN_READBACK = 6'h24;

    // Offsets inside the global block
    localparam logic [5:0] OFF_GLOBAL_CONTROL = 6'h00;
    localparam logic [5:0] OFF_GLOBAL_IRQ_STATUS = 6'h04;

    // Field positions
    localparam int BIT_IRQ_ENABLE = 0;
    localparam int BIT_DOUBLE_UPDATE = 1;
    localparam int BIT_PHASE = 0;
    localparam int BIT_SWAP_PAIR_A = 4;
    localparam int BIT_SWAP_PAIR_B = 5;
    localparam int BIT_SYNC_BASE = 4;

    // Pin order inside a four-bit output group
    localparam int PIN_AH = 0;
    localparam int PIN_AL = 1;
    localparam int PIN_BH = 2;
    localparam int PIN_BL = 3;

    // Reset values
    localparam logic [15:0] RST_PERIOD = 16'h0000;
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [15:0] RST_DEAD = 16'h0000;
    localparam logic [5:0] RST_DISABLE = 6'h00;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [1:0] RST_CONTROL = 2'h0;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// >>> verilog/pwmocs_top.sv
// PWM output control stage: center-aligned two-pair PWM units with an AHB-Lite register slave.
// Assumes hclk is the peripheral clock, single-word AHB-Lite transfers, one bus slave.
// Summary of operation
// - Per-unit polarity select picks active-high or active-low pins, latched at boundaries.
// - Duty and period values are held as sixteen-bit counts.
// - Single-update mode reuses one duty value for both half periods.
// - Double-update mode reloads duty values at the midpoint for the second half.
// - Channel A duty drives the A pins (the low-side signal only until the low-side duty register is written), channel B duty the B pins, two's complement.
// - Duty offsets high-side on-time from half of each half period; zero gives fifty percent.
// - Switching edges of each pair are moved by the dead-time count.
// - Timing unit signals are active high; with the polarity bit clear, a low pin turns the power device on.
// - Output-disable bits zero to three force their outputs off regardless of duty.
// - Disable changes take effect at period start, also at midpoint in double-update.
// - Reset clears all four output-disable bits.
// - Crossover routes the high-side signal to the low pin and vice versa.
// - Reset clears both crossover bits.
// - Dead time is applied after the crossover swap.
// - Each period start flags the unit; delivery needs its interrupt-enable bit.
// - Global status shows the source unit; software clears flags by writing ones.
// - A per-unit readback register returns the present state of its four pins.
// - Global control holds run and sync bits; writing it starts enabled units.
// - A programmed low-side duty register independently steers whichever A pin carries the low-side signal.
// - Unit status shows whether the timer is in the first or second half.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module pwmocs_top
    import pwmocs_pkg::*;
#(
    parameter int NUM_UNITS = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic pwm_irq,
    output logic [NUM_UNITS-1:0] pair_a_high_pin,
    output logic [NUM_UNITS-1:0] pair_a_low_pin,
    output logic [NUM_UNITS-1:0] pair_b_high_pin,
    output logic [NUM_UNITS-1:0] pair_b_low_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Half period length, never below one clock
    function automatic logic [15:0] half_of(input logic [15:0] per);
        half_of = (per == 16'h0000) ? 16'h0001 : per;
    endfunction

    // On-time per half period after dead time, signed
    function automatic logic signed [17:0] on_time(input logic [15:0] half,
                                                  input logic [15:0] duty,
                                                  input logic neg,
                                                  input logic [15:0] dead);
        logic signed [17:0] q;
        logic signed [17:0] d;
        q = $signed({3'b000, half[15:1]});
        d = $signed({{2{duty[15]}}, duty});
        on_time = (neg ? (q - d) : (q + d)) - $signed({2'b00, dead});
    endfunction

    // Commanded-on test: center-placed (high side) or edge-placed (low side) window
    function automatic logic pin_on(input logic [15:0] cnt, input logic [15:0] half,
                                    input logic signed [17:0] on, input logic center);
        logic signed [17:0] c;
        logic signed [17:0] h;
        c = $signed({2'b00, cnt});
        h = $signed({2'b00, half});
        pin_on = center ? (c >= (h - on)) : (c < on);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [1:0] unit_control [NUM_UNITS];
    logic [15:0] period_count [NUM_UNITS];
    logic [15:0] duty_chan_a [NUM_UNITS];
    logic [15:0] duty_chan_b [NUM_UNITS];
    logic [15:0] duty_chan_a_low [NUM_UNITS];
    logic [NUM_UNITS-1:0] low_duty_programmed;
    logic [15:0] dead_time_count [NUM_UNITS];
    logic [5:0] output_disable [NUM_UNITS];
    logic [3:0] polarity_select [NUM_UNITS];
    logic [NUM_UNITS-1:0] unit_run_bit, timer_sync_enable, global_irq_status;

    // Shadow copies used by the timing logic
    logic [15:0] sh_period [NUM_UNITS];
    logic [15:0] sh_duty_a [NUM_UNITS];
    logic [15:0] sh_duty_b [NUM_UNITS];
    logic [15:0] sh_duty_al [NUM_UNITS];
    logic [NUM_UNITS-1:0] sh_al_prog;
    logic [15:0] sh_dead [NUM_UNITS];
    logic [5:0] sh_disable [NUM_UNITS];
    logic [3:0] sh_polarity [NUM_UNITS];

    // Timer state
    logic [15:0] count [NUM_UNITS];
    logic [NUM_UNITS-1:0] phase, run_d, period_start, midpoint, shadow_load;
    logic [3:0] next_pins [NUM_UNITS];

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: address phase capture, zero wait states

    logic wr_pending, addr_valid;
    logic [11:0] wr_addr, a_addr;
    logic [31:0] next_rdata;

    assign addr_valid = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign a_addr = haddr[11:0];

    // Write request held from address phase into data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pending <= addr_valid && hwrite;
            if (addr_valid) begin
                wr_addr <= a_addr;
            end
        end
    end

    // Bus handshake outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // Write decode helpers
    logic wr_global;
    logic [PWMOCS_UNIT_IDX_W-1:0] wr_unit;
    logic [5:0] wr_off;
    assign wr_global = wr_pending && (wr_addr[11:6] == PWMOCS_GLOBAL_BASE[11:6]);
    assign wr_unit = wr_addr[PWMOCS_UNIT_SHIFT +: PWMOCS_UNIT_IDX_W];
    assign wr_off = wr_addr[5:0];

    // Read mux, built from the address phase so data stands in the data phase
    always_comb begin
        logic [PWMOCS_UNIT_IDX_W-1:0] u;
        u = a_addr[PWMOCS_UNIT_SHIFT +: PWMOCS_UNIT_IDX_W];
        next_rdata = 32'h0000_0000;
        if (a_addr[11:6] == PWMOCS_GLOBAL_BASE[11:6]) begin
            case (a_addr[5:0])
                OFF_GLOBAL_CONTROL: begin
                    next_rdata[NUM_UNITS-1:0] = unit_run_bit;
                    next_rdata[BIT_SYNC_BASE +: NUM_UNITS] = timer_sync_enable;
                end
                OFF_GLOBAL_IRQ_STATUS: next_rdata[NUM_UNITS-1:0] = global_irq_status;
                default: next_rdata = 32'h0000_0000;
            endcase
        end else if (a_addr[11:8] == 4'h0 && int'(u) < NUM_UNITS) begin
            case (a_addr[5:0])
                OFF_UNIT_CONTROL: next_rdata[1:0] = unit_control[u];
                OFF_UNIT_STATUS: next_rdata[BIT_PHASE] = phase[u];
                OFF_PERIOD_COUNT: next_rdata[15:0] = period_count[u];
                OFF_DUTY_CHAN_A: next_rdata[15:0] = duty_chan_a[u];
                OFF_DUTY_CHAN_B: next_rdata[15:0] = duty_chan_b[u];
                OFF_DUTY_CHAN_A_LOW: next_rdata[15:0] = duty_chan_a_low[u];
                OFF_DEAD_TIME_COUNT: next_rdata[15:0] = dead_time_count[u];
                OFF_OUTPUT_DISABLE: next_rdata[5:0] = output_disable[u];
                OFF_POLARITY_SELECT: next_rdata[3:0] = polarity_select[u];
                OFF_PIN_READBACK: begin
                    next_rdata[PIN_AH] = pair_a_high_pin[u];
                    next_rdata[PIN_AL] = pair_a_low_pin[u];
                    next_rdata[PIN_BH] = pair_b_high_pin[u];
                    next_rdata[PIN_BL] = pair_b_low_pin[u];
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-unit software registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                unit_control[i] <= RST_CONTROL;
                period_count[i] <= RST_PERIOD;
                duty_chan_a[i] <= RST_DUTY;
                duty_chan_b[i] <= RST_DUTY;
                duty_chan_a_low[i] <= RST_DUTY;
                dead_time_count[i] <= RST_DEAD;
                output_disable[i] <= RST_DISABLE;
                polarity_select[i] <= RST_POLARITY;
            end
            low_duty_programmed <= '0;
        end else if (wr_pending && wr_addr[11:8] == 4'h0) begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (int'(wr_unit) == i) begin
                    case (wr_off)
                        OFF_UNIT_CONTROL: unit_control[i] <= hwdata[1:0];
                        OFF_PERIOD_COUNT: period_count[i] <= hwdata[15:0];
                        OFF_DUTY_CHAN_A: duty_chan_a[i] <= hwdata[15:0];
                        OFF_DUTY_CHAN_B: duty_chan_b[i] <= hwdata[15:0];
                        OFF_DUTY_CHAN_A_LOW: begin
                            duty_chan_a_low[i] <= hwdata[15:0];
                            low_duty_programmed[i] <= 1'b1;
                        end
                        OFF_DEAD_TIME_COUNT: dead_time_count[i] <= hwdata[15:0];
                        OFF_OUTPUT_DISABLE: output_disable[i] <= hwdata[5:0];
                        OFF_POLARITY_SELECT: polarity_select[i] <= hwdata[3:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Global control and status

    // Run and sync bits; a write here starts the enabled units
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_run_bit <= '0;
            timer_sync_enable <= '0;
        end else if (wr_global && wr_off == OFF_GLOBAL_CONTROL) begin
            unit_run_bit <= hwdata[NUM_UNITS-1:0];
            timer_sync_enable <= hwdata[BIT_SYNC_BASE +: NUM_UNITS];
        end
    end

    // Sticky source flags: write one to clear, a new period start wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_irq_status <= '0;
        end else begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (period_start[i]) begin
                    global_irq_status[i] <= 1'b1;
                end else if (wr_global && wr_off == OFF_GLOBAL_IRQ_STATUS && hwdata[i]) begin
                    global_irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt line gated by each unit's enable bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_irq <= 1'b0;
        end else begin
            pwm_irq <= 1'b0;
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (global_irq_status[i] && unit_control[i][BIT_IRQ_ENABLE]) begin
                    pwm_irq <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer events

    always_comb begin
        for (int i = 0; i < NUM_UNITS; i++) begin
            period_start[i] = unit_run_bit[i] &&
                              ((phase[i] && count[i] == 16'h0000) || !run_d[i]);
            midpoint[i] = unit_run_bit[i] && run_d[i] && !phase[i] &&
                          (count[i] >= half_of(sh_period[i]) - 16'h0001);
            shadow_load[i] = !unit_run_bit[i] || period_start[i] ||
                             (midpoint[i] && unit_control[i][BIT_DOUBLE_UPDATE]);
        end
    end

    // Up count in the first half, down count in the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '{default: 16'h0000};
            phase <= '0;
            run_d <= '0;
        end else begin
            run_d <= unit_run_bit;
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (!unit_run_bit[i] || !run_d[i]) begin
                    count[i] <= 16'h0000;
                    phase[i] <= 1'b0;
                end else if (!phase[i]) begin
                    if (midpoint[i]) begin
                        phase[i] <= 1'b1;
                    end else begin
                        count[i] <= count[i] + 16'h0001;
                    end
                end else if (count[i] == 16'h0000) begin
                    phase[i] <= 1'b0;
                end else begin
                    count[i] <= count[i] - 16'h0001;
                end
            end
        end
    end

    // Shadow registers reloaded at the period boundary and, in double-update, midpoint
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_period <= '{default: RST_PERIOD};
            sh_duty_a <= '{default: RST_DUTY};
            sh_duty_b <= '{default: RST_DUTY};
            sh_duty_al <= '{default: RST_DUTY};
            sh_dead <= '{default: RST_DEAD};
            sh_disable <= '{default: RST_DISABLE};
            sh_polarity <= '{default: RST_POLARITY};
            sh_al_prog <= '0;
        end else begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (shadow_load[i]) begin
                    sh_period[i] <= period_count[i];
                    sh_duty_a[i] <= duty_chan_a[i];
                    sh_duty_b[i] <= duty_chan_b[i];
                    sh_duty_al[i] <= duty_chan_a_low[i];
                    sh_al_prog[i] <= low_duty_programmed[i];
                    sh_dead[i] <= dead_time_count[i];
                    sh_disable[i] <= output_disable[i];
                    sh_polarity[i] <= polarity_select[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output control: crossover, dead time, disable, polarity

    always_comb begin
        logic [15:0] hf, low_a;
        logic signed [17:0] on_ah, on_al, on_bh, on_bl;
        logic sw_a, sw_b;
        logic [3:0] cmd;
        {hf, low_a} = 32'h0000_0000;
        {on_ah, on_al, on_bh, on_bl} = '0;
        {sw_a, sw_b} = 2'b00;
        cmd = 4'h0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            hf = half_of(sh_period[i]);
            low_a = sh_al_prog[i] ? sh_duty_al[i] : sh_duty_a[i];
            sw_a = sh_disable[i][BIT_SWAP_PAIR_A];
            sw_b = sh_disable[i][BIT_SWAP_PAIR_B];
            // Swapped pins take the other side's waveform before dead time is cut
            on_ah = sw_a ? on_time(hf, low_a, 1'b1, sh_dead[i])
                         : on_time(hf, sh_duty_a[i], 1'b0, sh_dead[i]);
            on_al = sw_a ? on_time(hf, sh_duty_a[i], 1'b0, sh_dead[i])
                         : on_time(hf, low_a, 1'b1, sh_dead[i]);
            on_bh = sw_b ? on_time(hf, sh_duty_b[i], 1'b1, sh_dead[i])
                         : on_time(hf, sh_duty_b[i], 1'b0, sh_dead[i]);
            on_bl = sw_b ? on_time(hf, sh_duty_b[i], 1'b0, sh_dead[i])
                         : on_time(hf, sh_duty_b[i], 1'b1, sh_dead[i]);
            cmd[PIN_AH] = pin_on(count[i], hf, on_ah, !sw_a);
            cmd[PIN_AL] = pin_on(count[i], hf, on_al, sw_a);
            cmd[PIN_BH] = pin_on(count[i], hf, on_bh, !sw_b);
            cmd[PIN_BL] = pin_on(count[i], hf, on_bl, sw_b);
            // Disabled or stopped outputs are off
            cmd = cmd & ~sh_disable[i][3:0] & {4{unit_run_bit[i] & run_d[i]}};
            // Polarity bit clear: active low, on commands a low level
            next_pins[i] = ~(cmd ^ sh_polarity[i]);
        end
    end

    // Registered pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {pair_a_high_pin, pair_a_low_pin, pair_b_high_pin, pair_b_low_pin} <= '1;
        end else begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                pair_a_high_pin[i] <= next_pins[i][PIN_AH];
                pair_a_low_pin[i] <= next_pins[i][PIN_AL];
                pair_b_high_pin[i] <= next_pins[i][PIN_BH];
                pair_b_low_pin[i] <= next_pins[i][PIN_BL];
            end
        end
    end

endmodule
